// [meter_defs.svh]
// Purpose: Constants for the measurement scaling and peak hold block
// Assumes: 20 MHz aclk, byte-addressed AXI4-Lite register window
// Notes: Input units are uA (current), mV (volt), uV (millivolt mode)
`ifndef METER_DEFS_SVH
`define METER_DEFS_SVH
`define CLK_HZ 20000000
`define TICK_MS 100
`define STARTUP_MS 3000
`define STARTUP_TICKS (`STARTUP_MS / `TICK_MS)
`define NUM_CHANNELS 4
`define ADDR_W 8
////////////////////////////////////////////////////////////////////////
`define STAT_BASE 8'h40
`define GLOBAL_OFS 8'h50
`define CFG_SRC_LSB 0
`define CFG_MODE_LSB 2
`define CFG_SQUARE_BIT 4
`define CFG_LATCH_BIT 5
`define CFG_CTLPK_BIT 6
`define CFG0_RST 32'h0000_0000
`define CFG1_RST 32'h03E8_0000
`define CFG2_RST 32'h0000_0000
`define CFG3_RST 32'h000A_000A
////////////////////////////////////////////////////////////////////////
`define MA420_BEGIN 4000
`define MA420_END 20000
`define MA420_RECIP 268435
`define MA020_BEGIN 0
`define MA020_END 20000
`define MA020_RECIP 214748
`define VOLT_BEGIN 0
`define VOLT_END 10000
`define VOLT_RECIP 429497
`define MV_BEGIN 0
`define MV_END 150000
`define MV_RECIP 28633
`define NORM_FRAC 16
`define NORM_ROUND 32768
`define PCT_FULL 1000
`define DISP_MIN (-999)
`define DISP_MAX 9999
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [meter_pkg.sv]
// Purpose: Shared types of the measurement scaling and peak hold block
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Status codes are what the display panel decodes
`default_nettype none
package meter_pkg;
  typedef enum logic [1:0] {
    SRC_UNIV = 2'b00, SRC_DIGI = 2'b01, SRC_BUS = 2'b10, SRC_MATH = 2'b11
  } src_e;
  typedef enum logic [1:0] {
    MODE_MA420 = 2'b00, MODE_MA020 = 2'b01,
    MODE_VOLT = 2'b10, MODE_MV = 2'b11
  } mode_e;
  typedef enum logic [2:0] {
    ST_VALUE = 3'b000, ST_OVER = 3'b001, ST_UNDER = 3'b010,
    ST_FAULT = 3'b011, ST_OVFL = 3'b100, ST_IDENT = 3'b101
  } status_e;
  typedef enum logic {PK_SEEK_RISE = 1'b0, PK_SEEK_FALL = 1'b1} pk_state_e;
  typedef struct packed {
    logic valid;
    logic fault;
    logic signed [31:0] value;
  } univ_in_s;
  typedef struct packed {
    logic valid;
    logic signed [15:0] value;
  } src_in_s;
  typedef struct packed {
    status_e status;
    logic hold;
    logic signed [15:0] value;
  } chan_disp_s;
endpackage
`default_nettype wire

// [measurement_scaling_peak_hold.sv]
// Purpose: Four-channel scaling, range check and peak hold path
// Assumes: Samples arrive as one-cycle valid pulses on aclk
// Notes: Registers reached over AXI4-Lite; no stall on config writes
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`include "meter_defs.svh"
`default_nettype none
module measurement_scaling_peak_hold
  import meter_pkg::*;
#(
  parameter int NCH = `NUM_CHANNELS,
  parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire univ_in_s univ_in,
  input wire src_in_s digi_in [NCH],
  input wire src_in_s bus_in [NCH],
  input wire src_in_s math_in [NCH],
  input wire logic cancel_key,
  output var chan_disp_s disp_q [NCH],
  output logic signed [15:0] ctl_value_q [NCH],
  output logic meas_mode_q
);

  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("NCH must be 1 to 4");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data latched independently

  logic aw_full_q, w_full_q, bvalid_q, arready_q, rvalid_q, awready_q;
  logic wready_q;
  logic [`ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_take, w_take, wr_fire, ar_take, aw_full_d, w_full_d, rvalid_d;
  logic [31:0] cfg_q [NCH][4];
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  assign aw_take = awvalid & awready_q;
  assign w_take = wvalid & wready_q;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
  assign w_full_d = (w_full_q | w_take) & ~wr_fire;
  assign ar_take = arvalid & arready_q;
  assign rvalid_d = (rvalid_q & ~rready) | ar_take;
  assign wr_ok = (aw_addr_q < `STAT_BASE) && (32'(aw_addr_q[5:4]) < NCH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Config takes effect on the next sample; the datapath never waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_q[c][0] <= `CFG0_RST;
        cfg_q[c][1] <= `CFG1_RST;
        cfg_q[c][2] <= `CFG2_RST;
        cfg_q[c][3] <= `CFG3_RST;
      end
    end else if (wr_fire && wr_ok) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          cfg_q[aw_addr_q[5:4]][aw_addr_q[3:2]][b*8 +: 8] <=
            w_data_q[b*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b0;
    if (araddr < `STAT_BASE) begin
      if (32'(araddr[5:4]) < NCH) begin
        rd_word = cfg_q[araddr[5:4]][araddr[3:2]];
        rd_ok = 1'b1;
      end
    end else if (araddr < `GLOBAL_OFS) begin
      if (32'(araddr[3:2]) < NCH) begin
        rd_word = {12'h000, disp_q[araddr[3:2]]};
        rd_ok = 1'b1;
      end
    end else if (araddr == `GLOBAL_OFS) begin
      rd_word = {31'h0000_0000, meas_mode_q};
      rd_ok = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////
  // 100 ms tick and power-up identification period

  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [7:0] start_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_cnt_q <= 8'h00;
      meas_mode_q <= 1'b0;
    end else if (tick_q && !meas_mode_q) begin
      start_cnt_q <= start_cnt_q + 8'h01;
      if (start_cnt_q == 8'(`STARTUP_TICKS - 1)) meas_mode_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel datapath, all channels always active

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    src_e src;
    mode_e mode;
    logic square, latch, ctl_pk, src_valid, is_univ, ext, fault;
    logic under, over, ovfl, hold_en, peak_hit;
    logic signed [15:0] lo, hi, src_val, w16, ext_q, held_q, cur_val_q;
    logic signed [15:0] thr;
    logic [15:0] hold_time, hold_cnt_q;
    logic signed [10:0] lo_pct, hi_pct;
    logic signed [31:0] rb, re, rc, norm, sq, sel;
    logic signed [32:0] diff, wval;
    logic signed [53:0] prod;
    logic signed [63:0] sq_full;
    logic signed [16:0] span;
    logic signed [48:0] wprod;
    logic signed [47:0] xk, lo_lim, hi_lim;
    logic signed [17:0] wx, ex, th;
    status_e st, cur_st_q;
    pk_state_e pk_q;
    logic holding_q;

    assign src = src_e'(cfg_q[g][0][`CFG_SRC_LSB +: 2]);
    assign mode = mode_e'(cfg_q[g][0][`CFG_MODE_LSB +: 2]);
    assign square = cfg_q[g][0][`CFG_SQUARE_BIT];
    assign latch = cfg_q[g][0][`CFG_LATCH_BIT];
    assign ctl_pk = cfg_q[g][0][`CFG_CTLPK_BIT];
    assign lo = cfg_q[g][1][15:0];
    assign hi = cfg_q[g][1][31:16];
    assign lo_pct = {1'b0, cfg_q[g][2][9:0]};
    assign hi_pct = {1'b0, cfg_q[g][2][25:16]};
    assign thr = {1'b0, cfg_q[g][3][14:0]};
    assign hold_time = cfg_q[g][3][31:16];
    assign is_univ = (src == SRC_UNIV);

    always_comb begin
      src_valid = univ_in.valid;
      src_val = 16'h0000;
      unique case (src)
        SRC_UNIV: src_valid = univ_in.valid;
        SRC_DIGI: begin
          src_valid = digi_in[g].valid;
          src_val = digi_in[g].value;
        end
        SRC_BUS: begin
          src_valid = bus_in[g].valid;
          src_val = bus_in[g].value;
        end
        SRC_MATH: begin
          src_valid = math_in[g].valid;
          src_val = math_in[g].value;
        end
      endcase
    end

    always_comb begin
      rb = `MA420_BEGIN;
      re = `MA420_END;
      rc = `MA420_RECIP;
      unique case (mode)
        MODE_MA420: begin
          rb = `MA420_BEGIN;
          re = `MA420_END;
          rc = `MA420_RECIP;
        end
        MODE_MA020: begin
          rb = `MA020_BEGIN;
          re = `MA020_END;
          rc = `MA020_RECIP;
        end
        MODE_VOLT: begin
          rb = `VOLT_BEGIN;
          re = `VOLT_END;
          rc = `VOLT_RECIP;
        end
        MODE_MV: begin
          rb = `MV_BEGIN;
          re = `MV_END;
          rc = `MV_RECIP;
        end
      endcase
    end

    // Reciprocal multiply instead of a divider; error stays under 1e-5
    always_comb begin
      diff = 33'(univ_in.value) - 33'(rb);
      prod = 54'(diff) * 54'(rc);
      norm = prod[47:16];
      sq_full = 64'(norm) * 64'(norm);
      sq = sq_full[47:16];
      sel = square ? sq : norm;
      span = 17'(hi) - 17'(lo);
      wprod = 49'(sel) * 49'(span) + 49'(`NORM_ROUND);
      wval = 33'(wprod >>> `NORM_FRAC) + 33'(lo);
    end

    // Limits outside millivolt mode compared scaled by 1000 so no division is needed
    always_comb begin
      ext = (mode != MODE_MV);
      xk = 48'(univ_in.value) * 48'(`PCT_FULL);
      lo_lim = 48'(rb) * (48'(`PCT_FULL) - 48'(lo_pct));
      hi_lim = 48'(re) * (48'(`PCT_FULL) + 48'(hi_pct));
      under = ext ? (xk < lo_lim) : (univ_in.value < rb);
      over = ext ? (xk > hi_lim) : (univ_in.value > re);
      fault = univ_in.fault;
      if (is_univ) begin
        ovfl = (wval < 33'(`DISP_MIN)) || (wval > 33'(`DISP_MAX));
        w16 = wval[15:0];
      end else begin
        ovfl = (src_val < 16'(`DISP_MIN)) || (src_val > 16'(`DISP_MAX));
        w16 = src_val;
      end
      if (is_univ && fault) st = ST_FAULT;
      else if (is_univ && over) st = ST_OVER;
      else if (is_univ && under) st = ST_UNDER;
      else if (ovfl) st = ST_OVFL;
      else st = ST_VALUE;
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cur_val_q <= 16'h0000;
        cur_st_q <= ST_VALUE;
      end else if (src_valid) begin
        cur_val_q <= w16;
        cur_st_q <= st;
      end
    end

    assign wx = 18'(w16);
    assign ex = 18'(ext_q);
    assign th = 18'(thr);
    assign peak_hit = is_univ && src_valid && (st == ST_VALUE) &&
                      (pk_q == PK_SEEK_FALL) && (wx <= ex - th);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pk_q <= PK_SEEK_RISE;
        ext_q <= 16'h0000;
      end else if (!is_univ) begin
        pk_q <= PK_SEEK_RISE;
        ext_q <= w16;
      end else if (src_valid && st == ST_VALUE) begin
        unique case (pk_q)
          PK_SEEK_RISE: begin
            if (wx >= ex + th) begin
              pk_q <= PK_SEEK_FALL;
              ext_q <= w16;
            end else if (w16 < ext_q) begin
              ext_q <= w16;
            end
          end
          PK_SEEK_FALL: begin
            if (peak_hit) begin
              pk_q <= PK_SEEK_RISE;
              ext_q <= w16;
            end else if (w16 > ext_q) begin
              ext_q <= w16;
            end
          end
        endcase
      end
    end

    assign hold_en = latch || (hold_time != 16'h0000);

    // A peak in the cancel cycle wins so no detection is lost
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        holding_q <= 1'b0;
        held_q <= 16'h0000;
        hold_cnt_q <= 16'h0000;
      end else if (peak_hit && hold_en) begin
        holding_q <= 1'b1;
        held_q <= ext_q;
        hold_cnt_q <= 16'h0000;
      end else if (!is_univ || !hold_en || cancel_key) begin
        holding_q <= 1'b0;
      end else if (tick_q && holding_q && hold_time != 16'h0000) begin
        if (hold_cnt_q + 16'h0001 >= hold_time) holding_q <= 1'b0;
        hold_cnt_q <= hold_cnt_q + 16'h0001;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        disp_q[g] <= '{status: ST_IDENT, hold: 1'b0, value: 16'h0000};
        ctl_value_q[g] <= 16'h0000;
      end else begin
        if (!meas_mode_q) begin
          disp_q[g] <= '{status: ST_IDENT, hold: 1'b0, value: 16'h0000};
        end else if (holding_q) begin
          disp_q[g] <= '{status: ST_VALUE, hold: 1'b1, value: held_q};
        end else begin
          disp_q[g] <= '{status: cur_st_q, hold: 1'b0, value: cur_val_q};
        end
        ctl_value_q[g] <= (ctl_pk && holding_q) ? held_q : cur_val_q;
      end
    end
  end

endmodule // measurement_scaling_peak_hold
`default_nettype wire

// [meter_checker_assertions.sv]
// Purpose: Port checks for the scaling and peak hold block
// Assumes: Channel 0 is universal and channel 1 follows another source
// Notes: Startup window allows two cycles of slack for tick alignment
`include "meter_defs.svh"
`default_nettype none
module meter_checker
  import meter_pkg::*;
#(
  parameter int NCH = 4,
  parameter int TICK_CYCLES = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire chan_disp_s disp_q [NCH],
  input wire logic meas_mode_q
);
  int cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  // Response registers one cycle after both halves are held
  property p_wr_resp; s_wr_take |-> ##2 bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
  property p_rd_resp; s_rd_take |=> rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read answer");
  property p_b_stand;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("bvalid dropped");
  property p_r_stand;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("rvalid dropped");
  property p_ar_refuse; rvalid |-> !arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("arready early");
  property p_ident; !meas_mode_q |-> disp_q[0].status == ST_IDENT;
  endproperty
  a_ident: assert property (p_ident) else $error("no ident");
  property p_mode_keep; meas_mode_q |=> meas_mode_q; endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode lost");
  property p_startup;
    $rose(meas_mode_q) |-> cnt_q >= 30 * TICK_CYCLES - 2
      && cnt_q <= 30 * TICK_CYCLES + 2;
  endproperty
  a_startup: assert property (p_startup) else $error("startup len");
  property p_hold_status;
    disp_q[0].hold |-> disp_q[0].status == ST_VALUE;
  endproperty
  a_hold_status: assert property (p_hold_status) else $error("hold");
  property p_disp_range;
    disp_q[1].status == ST_VALUE |-> $signed(disp_q[1].value) >= -999
      && $signed(disp_q[1].value) <= 9999;
  endproperty
  a_disp_range: assert property (p_disp_range) else $error("range");
endmodule // meter_checker
bind measurement_scaling_peak_hold meter_checker #(
  .NCH(NCH), .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .disp_q, .meas_mode_q
);
`default_nettype wire

// [meter_front_end.sv]
// Purpose: Behavioural analog front end feeding universal samples
// Assumes: One sample is a single-cycle valid pulse
// Notes: Idle value is inverted so nothing stale passes as a sample
`default_nettype none
module meter_front_end
  import meter_pkg::*;
(
  input wire logic aclk,
  output var univ_in_s univ_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial univ_in = '0;
  task automatic send(input logic signed [31:0] v, input logic f);
    @(posedge aclk);
    univ_in <= '{1'b1, f, v};
    @(posedge aclk);
    univ_in <= '{1'b0, ~f, ~v};
  endtask
endmodule // meter_front_end
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the scaling and peak hold block
// Assumes: Tick shortened to 10 cycles
// Notes: Sample values avoid half-count rounding cases except 10000 uA on -300..1200 (262.5)
`include "meter_defs.svh"
`default_nettype none
module testbench
  import meter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NCH = 4;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, meas_mode_q, cancel_key;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  univ_in_s univ_in;
  src_in_s digi_in [NCH], bus_in [NCH], math_in [NCH];
  chan_disp_s disp_q [NCH];
  logic signed [15:0] ctl_value_q [NCH];
  int num_errors = 0, check_count = 0, cyc = 0;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  num_errors++; $display("FAIL %s exp %0d got %0d", n, e, g); end end
  measurement_scaling_peak_hold #(.NCH(NCH), .TICK_CYCLES(10)) uut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .univ_in, .digi_in,
    .bus_in, .math_in, .cancel_key, .disp_q, .ctl_value_q, .meas_mode_q
  );
  meter_front_end fe (.aclk, .univ_in);
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = `RESP_OKAY);
    logic aw, w;
    aw = 0;
    w = 0;
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) aw = 1;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) w = 1;
      if (wvalid && wready) wvalid <= 0;
    end
    do @(posedge aclk); while (!bvalid);
    `CHK("bresp", r, bresp)
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    `CHK("rdata", e, rdata)
    `CHK("rresp", r, rresp)
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic smp(input int v, input logic f, input status_e s,
      input int w, input logic h);
    fe.send(v, f);
    repeat (2) @(posedge aclk);
    `CHK("status", s, disp_q[0].status)
    `CHK("hold", h, disp_q[0].hold)
    if (s == ST_VALUE) `CHK("value", w[15:0], disp_q[0].value)
  endtask
  // Channel 1 digital, 2 field bus, 3 maths
  task automatic src(input logic signed [15:0] a, b, c);
    @(posedge aclk);
    digi_in[1] <= '{1'b1, a};
    bus_in[2] <= '{1'b1, b};
    math_in[3] <= '{1'b1, c};
    @(posedge aclk);
    digi_in[1].valid <= 1'b0;
    bus_in[2].valid <= 1'b0;
    math_in[3].valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cancel_key} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    for (int i = 0; i < NCH; i++) begin
      digi_in[i] = '0;
      bus_in[i] = '0;
      math_in[i] = '0;
    end
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rchk(8'h00, `CFG0_RST, `RESP_OKAY);
    rchk(8'h04, `CFG1_RST, `RESP_OKAY);
    rchk(8'h0C, `CFG3_RST, `RESP_OKAY);
    rchk(8'h60, 32'h0, `RESP_SLVERR);
    wr(8'h40, 32'h1, `RESP_SLVERR);
    wr(8'h08, 32'h0064_00C8);
    wr(8'h04, 32'h04B0_FED4);
    rchk(8'h04, 32'h04B0_FED4, `RESP_OKAY);
    wr(8'h0C, 32'h0000_000A);
    wr(8'h10, 32'h1);
    wr(8'h20, 32'h2);
    wr(8'h30, 32'h3);
    wait (cyc == 280);
    `CHK("ident", ST_IDENT, disp_q[0].status)
    `CHK("mode", 1'b0, meas_mode_q)
    wait (cyc == 320);
    `CHK("mode", 1'b1, meas_mode_q)
    @(posedge aclk);
    rchk(8'h50, 32'h0000_0001, `RESP_OKAY);
    fork
      wr(8'h2C, 32'h0005_000A);
      smp(10000, 0, ST_VALUE, 262, 0);
    join
    smp(20500, 0, ST_VALUE, 1247, 0);
    smp(3500, 0, ST_VALUE, -347, 0);
    smp(23000, 0, ST_OVER, 0, 0);
    smp(1000, 0, ST_UNDER, 0, 0);
    smp(10000, 1, ST_FAULT, 0, 0);
    wr(8'h00, 32'h10);
    smp(10000, 0, ST_VALUE, -89, 0);
    wr(8'h00, 32'h0C);
    smp(160000, 0, ST_OVER, 0, 0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hFED4_04B0);
    smp(12000, 0, ST_VALUE, 450, 0);
    wr(8'h00, 32'h44);
    wr(8'h04, 32'h03E8_0000);
    smp(5000, 0, ST_VALUE, 250, 0);
    smp(4000, 0, ST_VALUE, 200, 0);
    src(1234, 77, -5);
    `CHK("ch1", 16'sd1234, disp_q[1].value)
    `CHK("ch2", 16'sd77, disp_q[2].value)
    `CHK("ch3", -16'sd5, disp_q[3].value)
    rchk(8'h44, 32'h0000_04D2, `RESP_OKAY);
    src(0, 0, 0);
    src(500, 0, 0);
    src(0, 0, 0);
    `CHK("ch1hold", 1'b0, disp_q[1].hold)
    src(10000, 0, 0);
    `CHK("ovfl", ST_OVFL, disp_q[1].status)
    rchk(8'h44, 32'h0008_2710, `RESP_OKAY);
    // Peak tests run in 0..1000 counts, 16 uA per count
    wr(8'h00, 32'h40);
    wr(8'h0C, 32'h000A_000A);
    smp(4080, 0, ST_VALUE, 5, 0);
    smp(4000, 0, ST_VALUE, 0, 0);
    smp(8000, 0, ST_VALUE, 250, 0);
    smp(4000, 0, ST_VALUE, 250, 1);
    `CHK("ctl", 16'sd250, ctl_value_q[0])
    repeat (60) @(posedge aclk);
    smp(10000, 0, ST_VALUE, 250, 1);
    smp(4000, 0, ST_VALUE, 375, 1);
    repeat (60) @(posedge aclk);
    smp(6000, 0, ST_VALUE, 375, 1);
    repeat (60) @(posedge aclk);
    smp(6000, 0, ST_VALUE, 125, 0);
    wr(8'h00, 32'h60);
    wr(8'h0C, 32'h0000_000A);
    smp(8000, 0, ST_VALUE, 250, 0);
    smp(4000, 0, ST_VALUE, 250, 1);
    repeat (300) @(posedge aclk);
    smp(4000, 0, ST_VALUE, 250, 1);
    cancel_key <= 1;
    @(posedge aclk);
    cancel_key <= 0;
    repeat (3) @(posedge aclk);
    `CHK("cancel", 1'b0, disp_q[0].hold)
    stop_test();
  end
  // Tests take about 1000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    stop_test();
  end
endmodule // testbench
`default_nettype wire
